// ===== logic/fdc_pkg.sv
// Purpose : shared constants for the fan drive output control block
// Assumes : core clock of 200 MHz, host I/O cycles decoded upstream
// Notes   : all offsets, reset values and cycle counts live here
`default_nettype none

package fdc_pkg;

  // ==========================================================
  // host port offsets from the monitor base address
  localparam logic [15:0] PORT_INDEX_OFS = 16'h0005; // index pointer port
  localparam logic [15:0] PORT_DATA_OFS  = 16'h0006; // indexed data port

  // ==========================================================
  // register indexes
  localparam logic [6:0] IDX_SYS_FREQ  = 7'h00; // sys_fan_freq_config
  localparam logic [6:0] IDX_SYS_VALUE = 7'h01; // sys_fan_output_value
  localparam logic [6:0] IDX_CPU_FREQ  = 7'h02; // cpu_fan_freq_config
  localparam logic [6:0] IDX_CPU_VALUE = 7'h03; // cpu_fan_output_value
  localparam logic [6:0] IDX_FAN_CFG   = 7'h04; // fan output configuration
  localparam logic [6:0] IDX_BANK      = 7'h4E; // bank select
  localparam logic [6:0] IDX_ALARM_CTL = 7'h57; // alarm enable, bank 0
  localparam logic [6:0] IDX_BANKED    = 7'h50; // first bank-specific index
  localparam logic [7:0] BANK_ALARM    = 8'h00; // bank holding alarm ctl

  // ==========================================================
  // field positions
  localparam int FREQ_CLK_PICK_BIT = 7; // 0: 24 MHz, 1: 180 kHz
  localparam int ALARM_EN_BIT      = 7; // alarm enable in alarm ctl
  localparam int DC_LEVEL_LSB      = 2; // lowest used bit in DC mode

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_FREQ    = 8'h04; // both frequency registers
  localparam logic [5:0] RST_FAN_CFG = 6'h01; // system fan in DC mode
  localparam logic [7:0] RST_BANK    = 8'h00; // bank after reset
  localparam logic [6:0] RST_INDEX   = 7'h00; // index pointer after reset
  localparam logic [1:0] STRAP_SETTLE = 2'h3; // cycles before strap load

  // ==========================================================
  // clock rates and derived source tick accumulators
  localparam int CLK_HZ       = 200_000_000; // core clock
  localparam int SRC_FAST_HZ  = 24_000_000;  // fast pwm source
  localparam int SRC_SLOW_HZ  = 180_000;     // slow pwm source
  localparam int ACC_UNIT_HZ  = 20_000;      // common divisor of rates
  localparam logic [13:0] ACC_MOD = 14'(CLK_HZ / ACC_UNIT_HZ);
  localparam logic [13:0] ACC_FAST_STEP = 14'(SRC_FAST_HZ / ACC_UNIT_HZ);
  localparam logic [13:0] ACC_SLOW_STEP = 14'(SRC_SLOW_HZ / ACC_UNIT_HZ);

  // ==========================================================
  // alarm tone timing
  localparam int TONE_LOW_HZ  = 600;  // first tone
  localparam int TONE_HIGH_HZ = 1200; // second tone
  localparam int TONE_SLOT_MS = 500;  // length of each tone
  localparam int TONE_SLOT_CYC = (CLK_HZ / 1000) * TONE_SLOT_MS;
  localparam int TONE_LOW_HALF_CYC  = CLK_HZ / (2 * TONE_LOW_HZ);
  localparam int TONE_HIGH_HALF_CYC = CLK_HZ / (2 * TONE_HIGH_HZ);

  // tone sequencer states, gray along idle -> low -> high
  typedef enum logic [1:0] {
    TONE_IDLE = 2'b00,
    TONE_LOW  = 2'b01,
    TONE_HIGH = 2'b11
  } fdc_tone_e;

endpackage

`default_nettype wire

// ===== logic/fdc_top.sv
// Purpose : host register window, two fan drive outputs, alarm tone
// Assumes : host I/O strobes are synchronous one-cycle pulses on core_clk
// Notes   : fan default strap is a pin and is synchronised before use
`default_nettype none

// Functional notes
// - alarm pin open-drain, idles driving low
// - alternate 600 Hz and 1.2 kHz, half-second each
// - base address from high and low bytes
// - index port base+5, data port base+6
// - bank at 4Eh; 50h upward bank-selected
// - index pointer seven bits, resets zero
// - index first, then full-byte data access
// - system fan frequency only in PWM mode
// - processor fan frequency only in PWM mode
// - bit 7 picks 24 MHz or 180 kHz
// - divide source by prescale, then 256
// - processor duty equals value over 256, FFh full
// - output values load from strap after reset
// - config bits pick DC per fan
module fdc_top
#(
  parameter int unsigned TONE_SLOT   = fdc_pkg::TONE_SLOT_CYC,
  parameter int unsigned TONE_LOW_H  = fdc_pkg::TONE_LOW_HALF_CYC,
  parameter int unsigned TONE_HIGH_H = fdc_pkg::TONE_HIGH_HALF_CYC
)
(
  input  wire logic        core_clk,            // core clock, 200 MHz
  input  wire logic        rst_n,               // async reset, active low
  input  wire logic [7:0]  monitor_base_high,   // base address high byte
  input  wire logic [7:0]  monitor_base_low,    // base address low byte
  input  wire logic [15:0] io_addr,             // host I/O address
  input  wire logic        io_wr,               // host write strobe
  input  wire logic        io_rd,               // host read strobe
  input  wire logic [7:0]  io_wdata,            // host write data
  output var  logic [7:0]  io_rdata,            // host read data
  output var  logic        io_rvalid,           // read data valid pulse
  input  wire logic [7:0]  fan_default_strap,   // fan default strap pins
  input  wire logic        alarm_event,         // monitored event active
  output var  logic        alarm_tone_pin_out,  // open-drain output level
  output var  logic        alarm_tone_pin_oe,   // high while pulling low
  output var  logic        system_fan_drive,    // system fan pwm pin
  output var  logic        processor_fan_drive, // processor fan pwm pin
  output var  logic [5:0]  sys_fan_dc_level,    // system fan DC level
  output var  logic [5:0]  cpu_fan_dc_level     // processor fan DC level
);
  import fdc_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic [7:0]      strap_s1;    // strap sync, first stage
    logic [7:0]      strap_s2;    // strap sync, second stage
    logic [1:0]      strap_wait;  // settle count after reset
    logic            strap_done;  // strap copied into values
    logic [6:0]      index_ptr;   // index pointer
    logic [7:0]      bank;        // bank select
    logic [7:0]      sys_freq;    // sys_fan_freq_config
    logic [7:0]      sys_value;   // sys_fan_output_value
    logic [7:0]      cpu_freq;    // cpu_fan_freq_config
    logic [7:0]      cpu_value;   // cpu_fan_output_value
    logic [5:0]      fan_cfg;     // fan configuration bits
    logic            alarm_en;    // alarm enable
    logic [7:0]      rdata;       // read data
    logic            rvalid;      // read data valid
    logic [13:0]     acc_fast;    // 24 MHz tick accumulator
    logic [13:0]     acc_slow;    // 180 kHz tick accumulator
    logic            tick_fast;   // 24 MHz enable pulse
    logic            tick_slow;   // 180 kHz enable pulse
    logic [1:0][6:0] pre_cnt;     // prescale counters per fan
    logic [1:0][7:0] duty_cnt;    // 256-step period counters
    logic [1:0]      fan_pwm;     // pwm pin levels
    logic [1:0][5:0] dc_level;    // DC levels
    fdc_tone_e       tone;        // tone sequencer state
    logic [26:0]     slot_cnt;    // half-second slot count
    logic [17:0]     half_cnt;    // square wave half period count
    logic            tone_oe;     // pin pulled low
  } fdc_state_s;

  fdc_state_s q;      // registered state
  fdc_state_s next_q; // next state
  localparam logic [26:0] SLOT_LAST = 27'(TONE_SLOT - 1);
  localparam logic [17:0] LOW_LAST  = 18'(TONE_LOW_H - 1);
  localparam logic [17:0] HIGH_LAST = 18'(TONE_HIGH_H - 1);
  logic [15:0] base;       // monitor base address
  logic        index_hit;  // host addresses index port
  logic        data_hit;   // host addresses data port
  logic        banked;     // index lies in bank-specific range
  logic        alarm_on;   // alarm enabled and event present

  // ==========================================================
  // host address decode
  assign base      = {monitor_base_high, monitor_base_low};
  assign index_hit = io_addr == 16'(base + PORT_INDEX_OFS);
  assign data_hit  = io_addr == 16'(base + PORT_DATA_OFS);
  assign banked    = q.index_ptr >= IDX_BANKED;
  assign alarm_on  = q.alarm_en & alarm_event;

  // ==========================================================
  // next state
  always_comb
  begin
    logic [7:0]  freq;    // frequency register of this fan
    logic [7:0]  value;   // output value of this fan
    logic        dc;      // fan in DC mode
    logic        src;     // selected source tick
    logic [17:0] hlast;   // last count of this half period
    logic [14:0] sum;     // accumulator sum
    freq   = 8'h00;
    value  = 8'h00;
    dc     = 1'b0;
    src    = 1'b0;
    hlast  = 18'h0_0000;
    sum    = 15'h0000;
    next_q = q;
    next_q.rvalid = 1'b0;
    // strap sampling, load values once settled
    next_q.strap_s1 = fan_default_strap;
    next_q.strap_s2 = q.strap_s1;
    if (!q.strap_done)
    begin
      next_q.strap_wait = q.strap_wait + 2'h1;
      if (q.strap_wait == STRAP_SETTLE - 2'h1)
      begin
        next_q.sys_value  = q.strap_s2;
        next_q.cpu_value  = q.strap_s2;
        next_q.strap_done = 1'b1;
      end
    end
    // host writes
    if (io_wr && index_hit)
      next_q.index_ptr = io_wdata[6:0];
    else if (io_wr && data_hit)
    begin
      // data byte written to the selected location; fan cfg keeps bits 5:0 only, alarm ctl bit 7 only
      case (q.index_ptr)
        IDX_SYS_FREQ:  next_q.sys_freq  = io_wdata;
        IDX_SYS_VALUE: next_q.sys_value = io_wdata;
        IDX_CPU_FREQ:  next_q.cpu_freq  = io_wdata;
        IDX_CPU_VALUE: next_q.cpu_value = io_wdata;
        IDX_FAN_CFG:   next_q.fan_cfg   = io_wdata[5:0];
        IDX_BANK:      next_q.bank      = io_wdata;
        IDX_ALARM_CTL:
          // bank-specific location, only in bank 0
          if (q.bank == BANK_ALARM)
            next_q.alarm_en = io_wdata[ALARM_EN_BIT];
        default: ; // unmapped index, write dropped
      endcase
    end
    // host reads
    if (io_rd && index_hit)
    begin
      next_q.rdata  = {1'b0, q.index_ptr};
      next_q.rvalid = 1'b1;
    end
    else if (io_rd && data_hit)
    begin
      next_q.rvalid = 1'b1;
      case (q.index_ptr)
        IDX_SYS_FREQ:  next_q.rdata = q.sys_freq;
        IDX_SYS_VALUE: next_q.rdata = q.sys_value;
        IDX_CPU_FREQ:  next_q.rdata = q.cpu_freq;
        IDX_CPU_VALUE: next_q.rdata = q.cpu_value;
        IDX_FAN_CFG:   next_q.rdata = {2'b00, q.fan_cfg};
        IDX_BANK:      next_q.rdata = q.bank;
        IDX_ALARM_CTL: next_q.rdata = (banked && q.bank == BANK_ALARM) ?
                                      {q.alarm_en, 7'h00} : 8'h00;
        default:       next_q.rdata = 8'h00; // unmapped reads zero
      endcase
    end
    // source clock enables from fractional accumulators
    sum = {1'b0, q.acc_fast} + {1'b0, ACC_FAST_STEP};
    next_q.tick_fast = sum >= {1'b0, ACC_MOD};
    next_q.acc_fast  = next_q.tick_fast ? 14'(sum - {1'b0, ACC_MOD})
                                        : sum[13:0];
    sum = {1'b0, q.acc_slow} + {1'b0, ACC_SLOW_STEP};
    next_q.tick_slow = sum >= {1'b0, ACC_MOD};
    next_q.acc_slow  = next_q.tick_slow ? 14'(sum - {1'b0, ACC_MOD})
                                        : sum[13:0];
    // per-fan pwm and DC outputs, index 0 system, 1 processor
    for (int i = 0; i < 2; i++)
    begin
      freq  = (i == 0) ? q.sys_freq  : q.cpu_freq;
      value = (i == 0) ? q.sys_value : q.cpu_value;
      dc    = q.fan_cfg[i];
      src   = freq[FREQ_CLK_PICK_BIT] ? q.tick_slow : q.tick_fast;
      if (dc) // frequency settings idle in DC mode
      begin
        next_q.pre_cnt[i]  = 7'h00;
        next_q.duty_cnt[i] = 8'h00;
      end
      else if (src) // prescale then 256 steps per period
      begin
        if (({1'b0, q.pre_cnt[i]} + 8'h01) >= {1'b0, freq[6:0]})
        begin
          next_q.pre_cnt[i]  = 7'h00;
          next_q.duty_cnt[i] = q.duty_cnt[i] + 8'h01;
        end
        else
          next_q.pre_cnt[i] = q.pre_cnt[i] + 7'h01;
      end
      // duty: FFh full, zero none
      next_q.fan_pwm[i] = !dc && (value == 8'hFF ||
                                  q.duty_cnt[i] < value);
      next_q.dc_level[i] = dc ? value[7:DC_LEVEL_LSB] : 6'h00;
    end
    // alarm tone sequencer
    hlast = (q.tone == TONE_HIGH) ? HIGH_LAST : LOW_LAST;
    case (q.tone)
      TONE_IDLE:
      begin
        next_q.tone_oe = 1'b1;
        if (alarm_on)
        begin
          next_q.tone     = TONE_LOW;
          next_q.slot_cnt = 27'h000_0000;
          next_q.half_cnt = 18'h0_0000;
        end
      end
      TONE_LOW, TONE_HIGH:
      begin
        if (!alarm_on)
        begin
          next_q.tone    = TONE_IDLE;
          next_q.tone_oe = 1'b1;
        end
        else if (q.slot_cnt == SLOT_LAST)
        begin
          // swap tones each half second
          next_q.tone = (q.tone == TONE_LOW) ? TONE_HIGH : TONE_LOW;
          next_q.slot_cnt = 27'h000_0000;
          next_q.half_cnt = 18'h0_0000;
          next_q.tone_oe  = 1'b1;
        end
        else
        begin
          next_q.slot_cnt = q.slot_cnt + 27'h000_0001;
          if (q.half_cnt == hlast)
          begin
            next_q.half_cnt = 18'h0_0000;
            next_q.tone_oe  = !q.tone_oe;
          end
          else
            next_q.half_cnt = q.half_cnt + 18'h0_0001;
        end
      end
      default:
      begin
        next_q.tone    = TONE_IDLE;
        next_q.tone_oe = 1'b1;
      end
    endcase
  end

  // ==========================================================
  // state register
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q           <= '0;
      q.index_ptr <= RST_INDEX;
      q.bank      <= RST_BANK;
      q.sys_freq  <= RST_FREQ;
      q.cpu_freq  <= RST_FREQ;
      q.fan_cfg   <= RST_FAN_CFG;
      q.tone      <= TONE_IDLE;
      q.tone_oe   <= 1'b1;
    end
    else
    begin
      q <= next_q;
    end
  end

  // ==========================================================
  // outputs from flops, except the alarm pin level tied low
  assign io_rdata            = q.rdata;
  assign io_rvalid           = q.rvalid;
  assign alarm_tone_pin_out  = 1'b0; // open-drain: only ever pulls low
  assign alarm_tone_pin_oe   = q.tone_oe;
  assign system_fan_drive    = q.fan_pwm[0];
  assign processor_fan_drive = q.fan_pwm[1];
  assign sys_fan_dc_level    = q.dc_level[0];
  assign cpu_fan_dc_level    = q.dc_level[1];

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  idle_pulls_low_a: assert property (
    q.tone == TONE_IDLE |-> alarm_tone_pin_oe)
    else $error("alarm pin released while idle");
  tone_stops_a: assert property (
    !alarm_on |=> q.tone == TONE_IDLE ##1 alarm_tone_pin_oe)
    else $error("tone kept running after alarm cleared");
  index_store_a: assert property (
    io_wr && index_hit |=> {1'b0, q.index_ptr} == ($past(io_wdata) & 8'h7F))
    else $error("index pointer not stored from base plus five");
  bank_write_a: assert property (
    io_wr && data_hit && q.index_ptr == IDX_BANK |=> q.bank == $past(io_wdata))
    else $error("bank register not written");
  data_read_a: assert property (
    io_rd && data_hit && !index_hit && q.index_ptr == IDX_CPU_VALUE
    |=> io_rvalid && io_rdata == $past(q.cpu_value))
    else $error("data port read wrong byte");
  sys_dc_idle_a: assert property (
    q.fan_cfg[0] |=> !system_fan_drive && q.duty_cnt[0] == 8'h00)
    else $error("system fan pwm ran in DC mode");
  cpu_dc_level_a: assert property (
    q.fan_cfg[1] |=> !processor_fan_drive &&
                     cpu_fan_dc_level == 6'($past(q.cpu_value) >> 2))
    else $error("processor fan DC level wrong");
  full_duty_a: assert property (
    !q.fan_cfg[1] && q.cpu_value == 8'hFF |=> processor_fan_drive)
    else $error("full duty value did not hold pin high");
  zero_duty_a: assert property (
    q.sys_value == 8'h00 |=> !system_fan_drive)
    else $error("zero duty value drove pin high");
  strap_load_a: assert property (
    !q.strap_done && q.strap_wait == STRAP_SETTLE - 2'h1
    |=> q.sys_value == $past(q.strap_s2) && q.strap_done)
    else $error("output value not loaded from strap");
  fast_tick_a: assert property (
    q.tick_fast |=> !q.tick_fast)
    else $error("fast source tick not a single pulse");
  prescale_wrap_a: assert property (
    !q.fan_cfg[1] && q.cpu_freq == 8'h01 && q.tick_fast
    |=> q.pre_cnt[1] == 7'h00)
    else $error("prescale one did not divide by one");

endmodule
`default_nettype wire

// ===== test/fdc_host_model.sv
// Purpose : host processor model making single-byte I/O port cycles
// Assumes : requests launch 1 ns after a rising edge of core_clk
// Notes   : released lines carry inverted data, never the last value
`default_nettype none

module fdc_host_model
(
  input  wire logic        core_clk, // core clock
  output var  logic [15:0] io_addr,  // I/O address
  output var  logic        io_wr,    // write strobe
  output var  logic        io_rd,    // read strobe
  output var  logic [7:0]  io_wdata  // write data
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // idle bus at time zero
  initial
  begin
    io_addr  = 16'h0000;
    io_wr    = 1'b0;
    io_rd    = 1'b0;
    io_wdata = 8'h00;
  end

  // ==========================================================
  // one cycle: held until the taking edge, then released
  task automatic io_cycle(logic wr, logic rd, logic [15:0] a,
                          logic [7:0] d);
    @(posedge core_clk);
    #1;
    io_wr    = wr;
    io_rd    = rd;
    io_addr  = a;
    io_wdata = d;
    @(posedge core_clk);
    #1;
    io_wr    = 1'b0;
    io_rd    = 1'b0;
    io_addr  = ~a; // stale address hidden
    io_wdata = ~d; // stale data hidden
  endtask
endmodule

`default_nettype wire

// ===== test/test_fdc_top.sv
// Purpose : self-checking bench for the fan drive output control block
// Assumes : small tone parameters keep the alarm run short
// Notes   : read answers are queued and checked when io_rvalid pulses
`default_nettype none

module test_fdc_top;
  timeunit 1ns;
  timeprecision 100ps;
  import fdc_pkg::*;

  logic        core_clk, rst_n, alarm_event;   // clock, reset, event
  logic        io_wr, io_rd, io_rvalid;        // host strobes, answer
  logic        tone_out, tone_oe;              // alarm pin pair
  logic        sys_drv, cpu_drv;               // fan pwm pins
  logic [7:0]  monitor_base_high, monitor_base_low; // base bytes
  logic [7:0]  io_wdata, io_rdata, strap;      // data and strap
  logic [15:0] io_addr, base;                  // address, base
  logic [5:0]  sys_lvl, cpu_lvl;               // dc levels
  typedef struct { string what; logic [7:0] val; } fdc_note_s;
  fdc_note_s   notes[$];                       // expected read data
  int          n_fail, check_count;            // counters

  fdc_host_model fdc_host_model_inst (.core_clk(core_clk),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata));

  fdc_top #(.TONE_SLOT(40), .TONE_LOW_H(4), .TONE_HIGH_H(2)) fdc_top_inst (
    .core_clk(core_clk), .rst_n(rst_n),
    .monitor_base_high(monitor_base_high),
    .monitor_base_low(monitor_base_low), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .io_rvalid(io_rvalid),
    .fan_default_strap(strap), .alarm_event(alarm_event),
    .alarm_tone_pin_out(tone_out), .alarm_tone_pin_oe(tone_oe),
    .system_fan_drive(sys_drv), .processor_fan_drive(cpu_drv),
    .sys_fan_dc_level(sys_lvl), .cpu_fan_dc_level(cpu_lvl));

  // ==========================================================
  // clock, 5 ns period
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // ==========================================================
  // compare and report
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ==========================================================
  // register access: index first, then the data port
  task automatic reg_wr(logic [6:0] idx, logic [7:0] v);
    fdc_host_model_inst.io_cycle(1, 0, base + PORT_INDEX_OFS, {1'b0, idx});
    fdc_host_model_inst.io_cycle(1, 0, base + PORT_DATA_OFS, v);
  endtask

  task automatic reg_rd(string what, logic [6:0] idx, logic [7:0] exp);
    fdc_host_model_inst.io_cycle(1, 0, base + PORT_INDEX_OFS, {1'b0, idx});
    notes.push_back('{what, exp});
    fdc_host_model_inst.io_cycle(0, 1, base + PORT_DATA_OFS, 8'h00);
  endtask

  // counts high samples and level changes of one fan pin
  task automatic watch_fan(logic cpu, int n, output int hi, output int tr);
    logic prev, cur;
    hi = 0;
    tr = 0;
    prev = cpu ? cpu_drv : sys_drv;
    repeat (n)
    begin
      @(negedge core_clk);
      cur = cpu ? cpu_drv : sys_drv;
      hi += int'(cur === 1'b1);
      tr += int'(cur !== prev);
      prev = cur;
    end
  endtask

  // alarm pin must stay pulled-low idle (oe high) after stopping
  task automatic tone_idle(string what);
    int lows;
    lows = 0;
    repeat (3) @(negedge core_clk);
    repeat (40)
    begin
      @(negedge core_clk);
      lows += int'(tone_oe !== 1'b1);
    end
    check(what, 8'(lows), 8'h00);
  endtask

  // ==========================================================
  // answer monitor: oldest note against each read pulse
  always @(negedge core_clk)
    if (io_rvalid === 1'b1)
    begin
      if (notes.size() == 0)
        check("unrequested answer", 8'h01, 8'h00);
      else
      begin
        check(notes[0].what, io_rdata, notes[0].val);
        notes.delete(0);
      end
    end

  // ==========================================================
  // watchdog
  initial
  begin
    repeat (80000) @(posedge core_clk);
    n_fail++;
    give_verdict();
  end

  // ==========================================================
  // main sequence
  initial
  begin
    int hi, tr, run, n4, n2;
    logic prev;
    logic [7:0] v1, v2, vals[4];
    void'($urandom(32'h70c6_0608));
    rst_n = 1'b0;
    alarm_event = 1'b0;
    strap = 8'($urandom);
    monitor_base_high = 8'($urandom);
    monitor_base_low = 8'($urandom) & 8'hF0;
    base = {monitor_base_high, monitor_base_low};
    repeat (5) @(posedge core_clk);
    #1 rst_n = 1'b1;
    repeat (6) @(negedge core_clk);
    check("tone oe", {7'h0, tone_oe}, 8'h01);
    check("tone out", {7'h0, tone_out}, 8'h00);
    notes.push_back('{"index reset", 8'h00});
    fdc_host_model_inst.io_cycle(0, 1, base + PORT_INDEX_OFS, 0);
    reg_rd("sys freq", IDX_SYS_FREQ, RST_FREQ);
    reg_rd("sys value", IDX_SYS_VALUE, strap);
    reg_rd("cpu freq", IDX_CPU_FREQ, RST_FREQ);
    reg_rd("cpu value", IDX_CPU_VALUE, strap);
    reg_rd("fan cfg", IDX_FAN_CFG, {2'b00, RST_FAN_CFG});
    reg_rd("bank", IDX_BANK, RST_BANK);
    $display("test reset values done");

    fdc_host_model_inst.io_cycle(1, 0, base + PORT_INDEX_OFS, 8'hFF);
    notes.push_back('{"index bit7", 8'h7F});
    fdc_host_model_inst.io_cycle(0, 1, base + PORT_INDEX_OFS, 0);
    fdc_host_model_inst.io_cycle(0, 1, base + 16'h0007, 0);
    fdc_host_model_inst.io_cycle(0, 1, (base ^ 16'h0100) + 16'h0006, 0);
    for (int i = 0; i < 4; i++)
    begin
      vals[i] = 8'($urandom);
      if (i % 2 == 0)
        vals[i][6:0] = 7'(1 + $urandom % 127);
      reg_wr(7'(i), vals[i]);
    end
    fdc_host_model_inst.io_cycle(1, 0, base + 16'h0004, 8'h00);
    for (int i = 0; i < 4; i++)
      reg_rd("fan reg", 7'(i), vals[i]);
    $display("test host window done");

    reg_wr(IDX_BANK, 8'h01);
    reg_rd("bank set", IDX_BANK, 8'h01);
    reg_rd("global reg", IDX_CPU_VALUE, vals[3]);
    reg_wr(IDX_ALARM_CTL, 8'h80);
    reg_wr(IDX_BANK, BANK_ALARM);
    reg_rd("banked reg", IDX_ALARM_CTL, 8'h00);
    reg_wr(IDX_ALARM_CTL, 8'h80);
    reg_rd("alarm ctl", IDX_ALARM_CTL, 8'h80);
    $display("test banking done");

    v1 = 8'h20 + 8'($urandom % 192);
    reg_wr(IDX_FAN_CFG, 8'h00);
    reg_wr(IDX_SYS_FREQ, 8'h02);
    reg_wr(IDX_CPU_FREQ, 8'h01);
    reg_wr(IDX_CPU_VALUE, v1);
    reg_wr(IDX_SYS_VALUE, 8'hFF);
    watch_fan(1, 6400, hi, tr);
    check("cpu duty", 8'(hi > 25 * v1 - 60 && hi < 25 * v1 + 60), 1);
    check("cpu period", 8'(tr >= 5 && tr <= 7), 1);
    check("pwm dc level", {2'b00, sys_lvl}, 8'h00);
    watch_fan(0, 3000, hi, tr);
    check("sys full", 8'(hi == 3000), 1);
    reg_wr(IDX_SYS_VALUE, 8'h80);
    watch_fan(0, 8533, hi, tr);
    check("sys duty", 8'(hi > 4207 && hi < 4327), 1);
    check("sys period", 8'(tr >= 3 && tr <= 5), 1);
    reg_wr(IDX_CPU_VALUE, 8'h00);
    watch_fan(1, 3000, hi, tr);
    check("cpu zero", 8'(hi), 0);
    reg_wr(IDX_CPU_FREQ, 8'h81);
    reg_wr(IDX_CPU_VALUE, 8'h80);
    watch_fan(1, 5000, hi, tr);
    check("slow source", 8'(tr <= 1), 1);
    $display("test pwm done");

    v2 = 8'($urandom);
    reg_wr(IDX_FAN_CFG, 8'h03);
    reg_wr(IDX_SYS_VALUE, v1);
    reg_wr(IDX_CPU_VALUE, v2);
    watch_fan(0, 600, hi, tr);
    check("sys dc pin", 8'(hi), 0);
    watch_fan(1, 600, hi, tr);
    check("cpu dc pin", 8'(hi), 0);
    check("sys dc level", {2'b00, sys_lvl}, {2'b00, v1[7:2]});
    check("cpu dc level", {2'b00, cpu_lvl}, {2'b00, v2[7:2]});
    $display("test dc done");

    @(posedge core_clk);
    #1 alarm_event = 1'b1;
    prev = tone_oe;
    run = 0;
    n4 = 0;
    n2 = 0;
    repeat (120)
    begin
      @(negedge core_clk);
      run++;
      if (tone_oe !== prev)
      begin
        n4 += int'(run == 4);
        n2 += int'(run == 2);
        run = 0;
        prev = tone_oe;
      end
    end
    check("low tone runs", 8'(n4 >= 12), 1);
    check("high tone runs", 8'(n2 >= 16), 1);
    @(posedge core_clk);
    #1 alarm_event = 1'b0;
    tone_idle("event cleared");
    @(posedge core_clk);
    #1 alarm_event = 1'b1;
    repeat (20) @(posedge core_clk);
    reg_wr(IDX_ALARM_CTL, 8'h00);
    tone_idle("enable cleared");
    check("tone out idle", {7'h0, tone_out}, 8'h00);
    $display("test alarm done");

    // second reset in mid-run: values reload from a new strap
    strap = 8'($urandom);
    @(posedge core_clk);
    #1 rst_n = 1'b0;
    alarm_event = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 rst_n = 1'b1;
    repeat (6) @(negedge core_clk);
    reg_rd("sys value rst", IDX_SYS_VALUE, strap);
    reg_rd("cpu freq rst", IDX_CPU_FREQ, RST_FREQ);
    reg_rd("fan cfg rst", IDX_FAN_CFG, {2'b00, RST_FAN_CFG});
    $display("test mid reset done");

    repeat (5) @(posedge core_clk);
    check("answers pending", 8'(notes.size()), 8'h00);
    give_verdict();
  end
endmodule

`default_nettype wire
